// >>> design/smc_pkg.sv
// constants, modes and carrier structs of the standby mode controller
// assumes one 50 MHz system clock and a byte-wide register port
package smc_pkg;

    localparam logic [15:0] STAB_SEL_ADDR = 16'hfff4;
    localparam int STAB_SEL_LO_BIT = 0;
    localparam int STAB_SEL_HI_BIT = 1;
    // register comes up undefined; longest wait is the safe pick
    localparam logic [1:0] STAB_SEL_RESET = 2'h3;

    localparam int CLK_PERIOD_NS = 20;
    localparam int STOP_TIME_MIN_NS = 17000;
    localparam int STOP_TIME_TYP_NS = 34000;
    localparam int STOP_TIME_MAX_NS = 67000;
    // typical figure, rounded up to whole cycles
    localparam int STOP_TIME_CYC = (STOP_TIME_TYP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // stabilization waits in system clock periods, as powers of two
    localparam int STAB_EXP_0 = 10;
    localparam int STAB_EXP_1 = 12;
    localparam int STAB_EXP_2 = 15;
    localparam int STAB_EXP_3 = 17;
    localparam int STAB_CYC_0 = 1 << STAB_EXP_0;
    localparam int STAB_CYC_1 = 1 << STAB_EXP_1;
    localparam int STAB_CYC_2 = 1 << STAB_EXP_2;
    localparam int STAB_CYC_3 = 1 << STAB_EXP_3;
    localparam int TMR_W = 18;

    typedef enum logic [2:0] {
        SMC_BOOT = 3'b000,
        SMC_RUN = 3'b001,
        SMC_HALT = 3'b010,
        SMC_STOP = 3'b011,
        SMC_OSC_WAIT = 3'b100,
        SMC_STOP_TIME = 3'b101,
        SMC_STAB = 3'b110,
        SMC_RESUME = 3'b111
    } smc_mode_t;

    typedef struct packed {
        logic halt_exec;
        logic stop_exec;
        logic instr_done;
        logic irq_reg_access;
        logic global_irq_enable;
    } smc_cpu_t;

    typedef struct packed {
        logic slow_osc_stoppable;
        logic slow_osc_halt_bit;
        logic xtal_selected;
        logic wdt_on_slow_osc;
    } smc_clkcfg_t;

    typedef struct packed {
        logic cpu_clk_en;
        logic sys_osc_en;
        logic periph_clk_en;
        logic slow_osc_en;
        logic wdt_count_en;
        logic hold_io;
    } smc_clk_ctl_t;

    typedef struct packed {
        logic irq_ack;
        logic resume_next;
    } smc_wake_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } smc_reg_req_t;

endpackage

// >>> design/smc_sync.sv
// two-flop synchroniser for one level
// assumes the input is asynchronous to clk_sys
`timescale 1ns/1ps
module smc_sync (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // level
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic meta;
        logic q;
    } smc_sync_st_t;

    smc_sync_st_t st;
    smc_sync_st_t next_st;

    always_comb begin
        next_st.meta = din;
        next_st.q = st.meta;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.q;
endmodule

// >>> design/smc_timer.sv
// down-counting interval timer; done is high in the last of len cycles
// assumes start is a one-cycle pulse and len is at least one
`timescale 1ns/1ps
module smc_timer (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // control
    input wire logic start,
    input wire logic [smc_pkg::TMR_W-1:0] len,
    output logic done
);
    typedef struct packed {
        logic busy;
        logic [smc_pkg::TMR_W-1:0] cnt;
    } smc_tmr_st_t;

    smc_tmr_st_t st;
    smc_tmr_st_t next_st;

    always_comb begin
        next_st = st;
        if (start) begin
            next_st.busy = 1'b1;
            next_st.cnt = len - 18'h00001;
        end else if (st.busy) begin
            if (st.cnt == '0) begin
                next_st.busy = 1'b0;
            end else begin
                next_st.cnt = st.cnt - 18'h00001;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign done = st.busy && (st.cnt == '0);
endmodule

// >>> design/smc_top.sv
// standby mode controller: light sleep, deep sleep and the wake sequence
// assumes CPU strobes are on clk_sys; osc_running comes from the oscillator
// How it works
// R01: light sleep gates CPU clock, oscillator runs
// R02: running slow oscillator keeps running in light sleep
// R03: deep sleep stops the system oscillator
// R04: interrupt request ends deep sleep
// R05: fixed operation-stop interval after deep-sleep release
// R06: sleep holds registers, memory and port state
// R07: running slow oscillator cannot stop in deep sleep
// R08: slow halt bit acts only when option allows
// R09: watchdog halted during deep sleep
// R10: reset stops clocks; light sleep keeps them
// R11: stabilization wait only for crystal after deep sleep
// R12: select codes give 2^10, 2^12, 2^15, 2^17
// R13: select register: two bits, upper zero, byte written
// R14: software picks wait at least resonator time
// R15: wait counted from oscillation start only
// R16: software stops peripherals before deep sleep
// R17: software clears converter bits before sleeping
// R18: flag or mask access defers next acknowledge
// R19: light-sleep wake vectors if enabled, else continues
// R20: pending unmasked request ends sleep at once
// R21: CPU clock back one edge after wait
`timescale 1ns/1ps
module smc_top #(
    parameter int STAB_LEN_0 = smc_pkg::STAB_CYC_0,
    parameter int STAB_LEN_1 = smc_pkg::STAB_CYC_1,
    parameter int STAB_LEN_2 = smc_pkg::STAB_CYC_2,
    parameter int STAB_LEN_3 = smc_pkg::STAB_CYC_3
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // cpu side
    input wire smc_pkg::smc_cpu_t cpu,
    input wire logic [7:0] irq_request_flags,
    input wire logic [7:0] irq_mask_flags,
    output smc_pkg::smc_wake_t wake,
    // register port
    input wire smc_pkg::smc_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // clock sources and peripherals
    input wire smc_pkg::smc_clkcfg_t clk_cfg,
    input wire logic osc_running,
    output smc_pkg::smc_clk_ctl_t clk_ctl
);
    typedef struct packed {
        smc_pkg::smc_mode_t mode;
        logic [1:0] stab_sel;
        logic defer;
        logic slow_keep;
        logic [7:0] rdata;
        smc_pkg::smc_wake_t wake;
        smc_pkg::smc_clk_ctl_t clk;
    } smc_st_t;

    smc_st_t st;
    smc_st_t next_st;
    logic osc_ok;
    logic pend;
    logic slow_run;
    logic stop_start;
    logic stop_done;
    logic stab_start;
    logic stab_done;
    logic [smc_pkg::TMR_W-1:0] stab_len;

    // any request flag set with its mask clear
    function automatic logic irq_pending(input logic [7:0] flags, input logic [7:0] mask);
        irq_pending = |(flags & ~mask);
    endfunction

    function automatic logic in_deep(input smc_pkg::smc_mode_t m);
        in_deep = (m == smc_pkg::SMC_STOP) || (m == smc_pkg::SMC_OSC_WAIT) ||
            (m == smc_pkg::SMC_STOP_TIME) || (m == smc_pkg::SMC_STAB) ||
            (m == smc_pkg::SMC_RESUME);
    endfunction

    smc_sync u_osc_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .din(osc_running),
        .dout(osc_ok)
    );

    smc_timer u_stop_tmr (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .start(stop_start),
        .len(18'(smc_pkg::STOP_TIME_CYC)),
        .done(stop_done)
    );

    smc_timer u_stab_tmr (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .start(stab_start),
        .len(stab_len),
        .done(stab_done)
    );

    always_comb begin
        case (st.stab_sel)
            2'h0: stab_len = 18'(STAB_LEN_0); // R12
            2'h1: stab_len = 18'(STAB_LEN_1); // R12
            2'h2: stab_len = 18'(STAB_LEN_2); // R12
            default: stab_len = 18'(STAB_LEN_3); // R12
        endcase
    end

    always_comb begin
        next_st = st;
        next_st.wake = '0;
        stop_start = 1'b0;
        stab_start = 1'b0;
        pend = irq_pending(irq_request_flags, irq_mask_flags);
        // halt bit is ignored unless the option makes the oscillator stoppable
        slow_run = !(clk_cfg.slow_osc_stoppable && clk_cfg.slow_osc_halt_bit); // R08
        if (reg_req.wr && (reg_req.addr == smc_pkg::STAB_SEL_ADDR)) begin
            next_st.stab_sel = reg_req.wdata[smc_pkg::STAB_SEL_HI_BIT:smc_pkg::STAB_SEL_LO_BIT]; // R13
        end
        next_st.rdata = 8'h00;
        if (reg_req.rd && (reg_req.addr == smc_pkg::STAB_SEL_ADDR)) begin
            next_st.rdata = {6'h00, st.stab_sel}; // R13
        end
        if (cpu.instr_done) begin
            next_st.defer = cpu.irq_reg_access; // R18
        end
        case (st.mode)
            smc_pkg::SMC_BOOT: begin
                if (osc_ok) begin
                    next_st.mode = smc_pkg::SMC_RUN;
                end
            end
            smc_pkg::SMC_RUN: begin
                // oscillator state at entry is what sleep keeps
                next_st.slow_keep = slow_run; // R02 R07
                if (cpu.halt_exec) begin
                    next_st.mode = smc_pkg::SMC_HALT; // R01
                end else if (cpu.stop_exec) begin
                    next_st.mode = smc_pkg::SMC_STOP; // R03
                end else if (cpu.instr_done && pend && cpu.global_irq_enable &&
                        !st.defer && !cpu.irq_reg_access) begin
                    next_st.wake.irq_ack = 1'b1; // R18
                end
            end
            smc_pkg::SMC_HALT: begin
                if (pend) begin
                    next_st.mode = smc_pkg::SMC_RUN; // R20
                    next_st.wake.irq_ack = cpu.global_irq_enable; // R19
                    next_st.wake.resume_next = !cpu.global_irq_enable; // R19
                end
            end
            smc_pkg::SMC_STOP: begin
                if (pend) begin
                    next_st.mode = smc_pkg::SMC_OSC_WAIT; // R04 R20
                end
            end
            smc_pkg::SMC_OSC_WAIT: begin
                // start-up delay of the oscillator is not part of any count
                if (osc_ok) begin
                    next_st.mode = smc_pkg::SMC_STOP_TIME; // R15
                    stop_start = 1'b1; // R05
                end
            end
            smc_pkg::SMC_STOP_TIME: begin
                if (stop_done) begin
                    if (clk_cfg.xtal_selected) begin
                        next_st.mode = smc_pkg::SMC_STAB; // R11
                        stab_start = 1'b1; // R11
                    end else begin
                        next_st.mode = smc_pkg::SMC_RESUME; // R11
                    end
                end
            end
            smc_pkg::SMC_STAB: begin
                if (stab_done) begin
                    next_st.mode = smc_pkg::SMC_RESUME;
                end
            end
            smc_pkg::SMC_RESUME: begin
                next_st.mode = smc_pkg::SMC_RUN; // R21
                next_st.wake.irq_ack = cpu.global_irq_enable && pend;
                next_st.wake.resume_next = !(cpu.global_irq_enable && pend);
            end
            default: begin
                next_st.mode = smc_pkg::SMC_BOOT;
            end
        endcase
        next_st.clk.cpu_clk_en = (next_st.mode == smc_pkg::SMC_RUN); // R01 R21
        next_st.clk.sys_osc_en = (next_st.mode != smc_pkg::SMC_STOP); // R03
        next_st.clk.periph_clk_en = (next_st.mode == smc_pkg::SMC_RUN) ||
            (next_st.mode == smc_pkg::SMC_HALT); // R10
        if ((next_st.mode == smc_pkg::SMC_RUN) || (next_st.mode == smc_pkg::SMC_BOOT)) begin
            next_st.clk.slow_osc_en = slow_run; // R08
        end else begin
            next_st.clk.slow_osc_en = next_st.slow_keep; // R02 R07
        end
        // a watchdog on the slow clock would otherwise run on through deep sleep
        next_st.clk.wdt_count_en = !in_deep(next_st.mode); // R09
        // latches and buffers frozen; CPU state kept since its clock is gated
        next_st.clk.hold_io = (next_st.mode != smc_pkg::SMC_RUN) &&
            (next_st.mode != smc_pkg::SMC_BOOT); // R06
    end

    // reset clears every clock enable: all sources stopped while held
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st.mode <= smc_pkg::SMC_BOOT;
            st.stab_sel <= smc_pkg::STAB_SEL_RESET;
            st.defer <= 1'b0;
            st.slow_keep <= 1'b0;
            st.rdata <= 8'h00;
            st.wake <= '0;
            st.clk <= '0; // R10
        end else begin
            st <= next_st;
        end
    end

    assign wake = st.wake;
    assign clk_ctl = st.clk;
    assign reg_rdata = st.rdata;

    // helper counters for the interval checks
    logic [17:0] chk_cnt;
    logic [17:0] chk_len;
    smc_pkg::smc_mode_t chk_mode;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            chk_cnt <= 18'h00000;
            chk_len <= 18'h00000;
            chk_mode <= smc_pkg::SMC_BOOT;
        end else begin
            chk_mode <= st.mode;
            chk_cnt <= (st.mode == chk_mode) ? chk_cnt + 18'h00001 : 18'h00001;
            if (stab_start) begin
                chk_len <= stab_len;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    property p_halt_gate;
        (st.mode == smc_pkg::SMC_HALT) |-> !clk_ctl.cpu_clk_en && clk_ctl.sys_osc_en;
    endproperty
    a_halt_gate: assert property (p_halt_gate) else $error("cpu clock live in halt"); // R01

    property p_slow_keep;
        ((st.mode == smc_pkg::SMC_HALT) || (st.mode == smc_pkg::SMC_STOP)) && st.slow_keep
            |-> clk_ctl.slow_osc_en;
    endproperty
    a_slow_keep: assert property (p_slow_keep) else $error("slow osc stopped in sleep"); // R02 R07

    property p_stop_osc;
        (st.mode == smc_pkg::SMC_STOP) |-> !clk_ctl.sys_osc_en && !clk_ctl.periph_clk_en;
    endproperty
    a_stop_osc: assert property (p_stop_osc) else $error("oscillator on in stop"); // R03

    property p_stop_wake;
        (st.mode == smc_pkg::SMC_STOP) && pend |=> (st.mode == smc_pkg::SMC_OSC_WAIT);
    endproperty
    a_stop_wake: assert property (p_stop_wake) else $error("stop not released"); // R04 R20

    property p_stop_time;
        (st.mode != smc_pkg::SMC_STOP_TIME) && (chk_mode == smc_pkg::SMC_STOP_TIME)
            |-> (chk_cnt == 18'(smc_pkg::STOP_TIME_CYC));
    endproperty
    a_stop_time: assert property (p_stop_time) else $error("stop interval length wrong"); // R05

    property p_hold_io;
        (st.mode == smc_pkg::SMC_HALT) || (st.mode == smc_pkg::SMC_STOP) |-> clk_ctl.hold_io;
    endproperty
    a_hold_io: assert property (p_hold_io) else $error("ports not held in sleep"); // R06

    property p_slow_locked;
        (st.mode == smc_pkg::SMC_RUN) && !clk_cfg.slow_osc_stoppable |=> clk_ctl.slow_osc_en;
    endproperty
    a_slow_locked: assert property (p_slow_locked) else $error("slow osc stopped"); // R08

    property p_wdt;
        in_deep(st.mode) |-> !clk_ctl.wdt_count_en;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog runs in stop"); // R09

    property p_halt_clocks;
        (st.mode == smc_pkg::SMC_HALT) |-> clk_ctl.periph_clk_en && clk_ctl.sys_osc_en;
    endproperty
    a_halt_clocks: assert property (p_halt_clocks) else $error("halt lost clocks"); // R10

    property p_no_stab;
        (st.mode == smc_pkg::SMC_STOP_TIME) && stop_done && !clk_cfg.xtal_selected
            |=> (st.mode == smc_pkg::SMC_RESUME);
    endproperty
    a_no_stab: assert property (p_no_stab) else $error("wait without crystal"); // R11

    property p_stab_len;
        (st.mode != smc_pkg::SMC_STAB) && (chk_mode == smc_pkg::SMC_STAB)
            |-> (chk_cnt == chk_len);
    endproperty
    a_stab_len: assert property (p_stab_len) else $error("stabilization length wrong"); // R12

    property p_reg_wr;
        reg_req.wr && (reg_req.addr == smc_pkg::STAB_SEL_ADDR)
            |=> (st.stab_sel == $past(reg_req.wdata[1:0]));
    endproperty
    a_reg_wr: assert property (p_reg_wr) else $error("select write lost"); // R13

    property p_osc_first;
        (st.mode == smc_pkg::SMC_OSC_WAIT) && !osc_ok |=> (st.mode == smc_pkg::SMC_OSC_WAIT);
    endproperty
    a_osc_first: assert property (p_osc_first) else $error("wait began early"); // R15

    property p_defer;
        (st.mode == smc_pkg::SMC_RUN) && st.defer && cpu.instr_done |=> !wake.irq_ack;
    endproperty
    a_defer: assert property (p_defer) else $error("deferred ack taken"); // R18

    property p_halt_vec;
        (st.mode == smc_pkg::SMC_HALT) && pend
            |=> (wake.irq_ack == $past(cpu.global_irq_enable)) && clk_ctl.cpu_clk_en;
    endproperty
    a_halt_vec: assert property (p_halt_vec) else $error("halt wake wrong"); // R19

    property p_resume;
        (st.mode == smc_pkg::SMC_RESUME) |=> clk_ctl.cpu_clk_en && (wake != 2'b00);
    endproperty
    a_resume: assert property (p_resume) else $error("cpu clock not back"); // R21
endmodule

// >>> sim/smc_osc_model.sv
// behavioural system oscillator: reports oscillation a set number of cycles after enable
// assumes osc_en is the controller's registered oscillator enable on clk_sys
`timescale 1ns/1ps
module smc_osc_model (
    // clock
    input wire logic clk_sys,
    // control
    input wire logic osc_en,
    input wire logic [7:0] start_delay,
    // status
    output logic osc_running
);
    logic [7:0] cnt;

    // start delay may exceed the shortest programmed wait; the wait counts from oscillation start
    always @(posedge clk_sys) begin
        if (osc_en !== 1'b1) begin
            cnt <= 8'h00;
            osc_running <= 1'b0;
        end else if (cnt < start_delay) begin
            cnt <= cnt + 8'h01;
        end else begin
            osc_running <= 1'b1;
        end
    end
endmodule

// >>> sim/tb_top.sv
// self-checking bench for the standby mode controller
// assumes smc_pkg and the design files are compiled first; stabilization waits shortened
`timescale 1ns/1ps
module tb_top;
    localparam int STAB_LEN[4] = '{4, 8, 16, 32};
    localparam logic [15:0] ADDR = smc_pkg::STAB_SEL_ADDR;
    logic clk_sys;
    logic sys_rst;
    smc_pkg::smc_cpu_t cpu;
    logic [7:0] irq_request_flags;
    logic [7:0] irq_mask_flags;
    smc_pkg::smc_wake_t wake;
    smc_pkg::smc_reg_req_t reg_req;
    logic [7:0] reg_rdata;
    smc_pkg::smc_clkcfg_t clk_cfg;
    logic osc_running;
    smc_pkg::smc_clk_ctl_t clk_ctl;
    logic [7:0] osc_delay;
    int num_errors;
    int cmp_count;

    smc_top #(.STAB_LEN_0(STAB_LEN[0]), .STAB_LEN_1(STAB_LEN[1]),
              .STAB_LEN_2(STAB_LEN[2]), .STAB_LEN_3(STAB_LEN[3])) dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .cpu(cpu),
        .irq_request_flags(irq_request_flags), .irq_mask_flags(irq_mask_flags),
        .wake(wake), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .clk_cfg(clk_cfg), .osc_running(osc_running), .clk_ctl(clk_ctl)
    );

    smc_osc_model osc (
        .clk_sys(clk_sys), .osc_en(clk_ctl.sys_osc_en),
        .start_delay(osc_delay), .osc_running(osc_running)
    );

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t %s got=%h exp=%h", $time, what, got, exp);
        end
    endtask

    task report_and_stop;
        $display("compares=%0d mismatches=%0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task reg_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_req.wr <= 1'b1;
        reg_req.addr <= a;
        reg_req.wdata <= d;
        @(posedge clk_sys);
        reg_req.wr <= 1'b0;
    endtask

    // read data stands one cycle, then returns to zero
    task reg_rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_req.rd <= 1'b1;
        reg_req.addr <= a;
        @(posedge clk_sys);
        reg_req.rd <= 1'b0;
        @(negedge clk_sys);
        chk(reg_rdata, exp, "read data");
        @(negedge clk_sys);
        chk(reg_rdata, 8'h00, "read data after");
    endtask

    task sleep_strobe(input logic deep);
        @(posedge clk_sys);
        cpu.halt_exec <= !deep;
        cpu.stop_exec <= deep;
        @(posedge clk_sys);
        cpu.halt_exec <= 1'b0;
        cpu.stop_exec <= 1'b0;
        @(negedge clk_sys);
    endtask

    task done_pulse(input logic acc, input logic exp);
        @(posedge clk_sys);
        cpu.instr_done <= 1'b1;
        cpu.irq_reg_access <= acc;
        @(posedge clk_sys);
        cpu.instr_done <= 1'b0;
        cpu.irq_reg_access <= 1'b0;
        @(negedge clk_sys);
        chk(wake.irq_ack, exp, "ack after instruction");
    endtask

    task t_boot;
        int n;
        n = 0;
        while (clk_ctl.cpu_clk_en !== 1'b1 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        chk(clk_ctl.cpu_clk_en, 1'b1, "cpu clock after boot");
        reg_rd(ADDR, 8'h03);
        $display("boot done");
    endtask

    task t_reg;
        reg_wr(ADDR, 8'hfe);
        reg_rd(ADDR, 8'h02);
        reg_wr(ADDR, 8'h01);
        reg_wr(16'hfff5, 8'h03);
        reg_rd(ADDR, 8'h01);
        reg_rd(16'hfff5, 8'h00);
        $display("register done");
    endtask

    // pending=1: request already waiting at entry, wake must follow at once
    task t_halt(input logic ie, input logic pending);
        @(posedge clk_sys);
        cpu.global_irq_enable <= ie;
        irq_request_flags <= 8'h02;
        irq_mask_flags <= pending ? 8'hfd : 8'hff;
        sleep_strobe(1'b0);
        chk(clk_ctl.cpu_clk_en, 1'b0, "halt cpu clock");
        chk(clk_ctl.sys_osc_en, 1'b1, "halt oscillator");
        chk(clk_ctl.periph_clk_en, 1'b1, "halt peripheral clock");
        chk(clk_ctl.slow_osc_en, 1'b1, "halt slow oscillator");
        chk(clk_ctl.hold_io, 1'b1, "halt holds io");
        if (!pending) begin
            repeat (4) @(negedge clk_sys);
            chk(clk_ctl.cpu_clk_en, 1'b0, "masked request keeps halt");
            @(posedge clk_sys);
            irq_mask_flags <= 8'hfd;
        end
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk(clk_ctl.cpu_clk_en, 1'b1, "halt released");
        chk(wake.irq_ack, ie, "vectored wake");
        chk(wake.resume_next, !ie, "resume wake");
        @(posedge clk_sys);
        irq_request_flags <= 8'h00;
        irq_mask_flags <= 8'hff;
        $display("halt ie=%0d pending=%0d done", ie, pending);
    endtask

    task t_defer;
        @(posedge clk_sys);
        cpu.global_irq_enable <= 1'b1;
        irq_request_flags <= 8'h08;
        irq_mask_flags <= 8'hf7;
        done_pulse(1'b1, 1'b0);
        done_pulse(1'b0, 1'b0);
        done_pulse(1'b0, 1'b1);
        @(posedge clk_sys);
        irq_request_flags <= 8'h00;
        irq_mask_flags <= 8'hff;
        $display("defer done");
    endtask

    task t_slow;
        @(posedge clk_sys);
        clk_cfg.slow_osc_halt_bit <= 1'b1;
        repeat (3) @(negedge clk_sys);
        chk(clk_ctl.slow_osc_en, 1'b1, "halt bit without option");
        @(posedge clk_sys);
        clk_cfg.slow_osc_stoppable <= 1'b1;
        repeat (3) @(negedge clk_sys);
        chk(clk_ctl.slow_osc_en, 1'b0, "halt bit with option");
        @(posedge clk_sys);
        clk_cfg.slow_osc_stoppable <= 1'b0;
        clk_cfg.slow_osc_halt_bit <= 1'b0;
        repeat (3) @(posedge clk_sys);
        $display("slow oscillator done");
    endtask

    // cycles from oscillation start to cpu clock back
    task deep(input logic xtal, input logic [1:0] sel, input logic [7:0] dly, output int cyc);
        @(posedge clk_sys);
        clk_cfg.xtal_selected <= xtal;
        cpu.global_irq_enable <= 1'b0;
        osc_delay <= dly;
        reg_wr(ADDR, {6'h00, sel});
        // no peripheral or converter activity is left running here
        sleep_strobe(1'b1);
        chk(clk_ctl.sys_osc_en, 1'b0, "deep oscillator");
        chk(clk_ctl.periph_clk_en, 1'b0, "deep peripheral clock");
        chk(clk_ctl.slow_osc_en, 1'b1, "deep slow oscillator");
        chk(clk_ctl.wdt_count_en, 1'b0, "deep watchdog");
        chk(clk_ctl.hold_io, 1'b1, "deep holds io");
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(clk_ctl.cpu_clk_en, 1'b0, "deep held without request");
        @(posedge clk_sys);
        irq_request_flags <= 8'h01;
        irq_mask_flags <= 8'hfe;
        cyc = 0;
        while (osc_running !== 1'b1 && cyc < 300) begin
            @(negedge clk_sys);
            cyc++;
        end
        chk(osc_running, 1'b1, "oscillator restarted");
        cyc = 0;
        while (clk_ctl.cpu_clk_en !== 1'b1 && cyc < 5000) begin
            @(negedge clk_sys);
            cyc++;
        end
        // enable is off here, so the wake must be a plain resume
        chk(wake, 2'b01, "deep wake resumes");
        chk(clk_ctl.hold_io, 1'b0, "deep wake frees io");
        chk(clk_ctl.wdt_count_en, 1'b1, "deep wake watchdog");
        @(posedge clk_sys);
        irq_request_flags <= 8'h00;
        irq_mask_flags <= 8'hff;
        $display("deep xtal=%0d sel=%0d delay=%0d took %0d", xtal, sel, dly, cyc);
    endtask

    task t_deep;
        int d0;
        int d;
        deep(1'b0, 2'h0, 8'h03, d0);
        chk(d0 >= 850 && d0 <= 3350, 1'b1, "operation stop interval");
        deep(1'b0, 2'h3, 8'h03, d);
        chk(d, d0, "no wait without crystal");
        for (int s = 0; s < 4; s++) begin
            deep(1'b1, s[1:0], 8'h03, d);
            chk(d, d0 + STAB_LEN[s], "stabilization wait");
        end
        deep(1'b1, 2'h0, 8'h28, d);
        chk(d, d0 + STAB_LEN[0], "wait after slow start");
        $display("deep sleep done");
    endtask

    initial begin
        repeat (60000) @(posedge clk_sys);
        num_errors++;
        $display("[FAIL] t=%0t watchdog got=%h exp=%h", $time, 1'b1, 1'b0);
        report_and_stop();
    end

    initial begin
        num_errors = 0;
        cmp_count = 0;
        sys_rst = 1'b1;
        cpu = '0;
        irq_request_flags = 8'h00;
        irq_mask_flags = 8'hff;
        reg_req = '0;
        clk_cfg = '0;
        clk_cfg.wdt_on_slow_osc = 1'b1;
        osc_delay = 8'h03;
        repeat (11) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(clk_ctl, '0, "clocks in reset");
        @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_boot();
        t_reg();
        t_halt(1'b1, 1'b0);
        t_halt(1'b0, 1'b0);
        t_halt(1'b0, 1'b1);
        t_defer();
        t_slow();
        t_deep();
        report_and_stop();
    end
endmodule
